// ==== include/psd_pkg.sv ====
package psd_pkg;

	// ==========================================================
	// Serial word layout
	localparam int SHIFT_W = 20;
	localparam int REF_SHIFT_W = 16;
	localparam int STEER_BIT = 0;
	localparam int REF_CNT_LSB = 1;
	localparam int REF_CNT_MSB = 14;
	localparam int REF_SEL_BIT = 15;
	localparam int SWAL_LSB = 1;
	localparam int SWAL_MSB = 8;
	localparam int PROG_LSB = 9;
	localparam int PROG_MSB = 19;

	// ==========================================================
	// Latch and counter widths
	localparam int REF_LATCH_W = 15;
	localparam int MAIN_LATCH_W = 19;
	localparam int REF_CNT_W = 14;
	localparam int SWAL_W = 8;
	localparam int PROG_W = 11;
	localparam int LATCH_SEL_BIT = 14;
	localparam int LATCH_PROG_LSB = 8;

	// ==========================================================
	// Reset values and limits
	localparam logic [14:0] REF_LATCH_RST = 15'h4008;
	localparam logic [18:0] MAIN_LATCH_RST = 19'h01000;
	localparam logic [13:0] REF_CNT_RST = 14'h0008;
	localparam logic [10:0] PROG_CNT_RST = 11'h010;
	localparam logic [7:0] SWAL_CNT_RST = 8'h00;
	localparam logic [15:0] TERMINAL_COUNT = 16'h0001;

	// ==========================================================
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	// ==========================================================
	// Phase detector states
	typedef enum logic [1:0] {
		PFD_IDLE,
		PFD_UP,
		PFD_DOWN
	} psd_pfd_t;

endpackage

// ==== logic/psd_core.sv ====
module psd_core #(
	parameter int REF_W = psd_pkg::REF_CNT_W,
	parameter int SWAL_W = psd_pkg::SWAL_W,
	parameter int PROG_W = psd_pkg::PROG_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic load_strobe,
	input wire logic phase_sense_pin,
	input wire logic prescaler_pulse_in,
	output logic prescaler_ratio_select,
	output logic modulus_high,
	output logic lock_indicator,
	output logic pump_out,
	output logic pump_oe,
	output logic phase_ref_out,
	output logic phase_fb_out,
	output logic phase_fb_oe,
	output logic loop_switch_out,
	output logic loop_switch_oe,
	output logic divider_monitor
);

	// ==========================================================
	// Elaboration checks
	generate
		if (REF_W != psd_pkg::REF_CNT_W || SWAL_W != psd_pkg::SWAL_W ||
			PROG_W != psd_pkg::PROG_W) begin : g_bad_width
			$error("psd_core: counter widths must match the serial word layout");
		end
	endgenerate

	function automatic logic at_terminal(input logic [15:0] value);
		at_terminal = (value <= psd_pkg::TERMINAL_COUNT);
	endfunction

	// ==========================================================
	// Link domain: shift register
	// No reset here: the shift clock stands still outside words, and
	// contents only matter once a full word has been clocked in.
	logic [psd_pkg::SHIFT_W-1:0] shift_reg;
	logic [psd_pkg::SHIFT_W-1:0] next_shift_reg;

	always_comb begin
		next_shift_reg = {shift_reg[psd_pkg::SHIFT_W-2:0], ser_data};
	end

	always_ff @(posedge ser_clk) begin
		shift_reg <= next_shift_reg;
	end

	// ==========================================================
	// Pin synchronisers
	logic [psd_pkg::SYNC_STAGES-1:0] strobe_sync;
	logic [psd_pkg::SYNC_STAGES-1:0] sense_sync;
	logic [psd_pkg::SYNC_STAGES-1:0] pulse_sync;
	logic pulse_prev;
	logic [psd_pkg::SYNC_STAGES-1:0] next_strobe_sync;
	logic [psd_pkg::SYNC_STAGES-1:0] next_sense_sync;
	logic [psd_pkg::SYNC_STAGES-1:0] next_pulse_sync;
	logic next_pulse_prev;
	logic strobe_level;
	logic sense_level;
	logic pulse_edge;

	always_comb begin
		next_strobe_sync = {strobe_sync[0], load_strobe};
		next_sense_sync = {sense_sync[0], phase_sense_pin};
		next_pulse_sync = {pulse_sync[0], prescaler_pulse_in};
		next_pulse_prev = pulse_sync[psd_pkg::SYNC_STAGES-1];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			// Low, so leaving reset never copies a shift register not yet loaded
			strobe_sync <= '0;
			sense_sync <= '1;
			pulse_sync <= '0;
			pulse_prev <= 1'b0;
		end else begin
			strobe_sync <= next_strobe_sync;
			sense_sync <= next_sense_sync;
			pulse_sync <= next_pulse_sync;
			pulse_prev <= next_pulse_prev;
		end
	end

	assign strobe_level = strobe_sync[psd_pkg::SYNC_STAGES-1];
	assign sense_level = sense_sync[psd_pkg::SYNC_STAGES-1];
	assign pulse_edge = pulse_sync[psd_pkg::SYNC_STAGES-1] & ~pulse_prev;

	// ==========================================================
	// Latches
	// Shift register is read across domains only while the strobe is
	// high, when the host keeps the shift clock still.
	logic [psd_pkg::REF_LATCH_W-1:0] ref_latch;
	logic [psd_pkg::MAIN_LATCH_W-1:0] main_latch;
	logic [psd_pkg::REF_LATCH_W-1:0] next_ref_latch;
	logic [psd_pkg::MAIN_LATCH_W-1:0] next_main_latch;

	always_comb begin
		next_ref_latch = ref_latch;
		next_main_latch = main_latch;
		if (strobe_level) begin
			if (shift_reg[psd_pkg::STEER_BIT]) begin
				next_ref_latch = shift_reg[psd_pkg::REF_SEL_BIT:psd_pkg::REF_CNT_LSB];
			end else begin
				next_main_latch = shift_reg[psd_pkg::PROG_MSB:psd_pkg::SWAL_LSB];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ref_latch <= psd_pkg::REF_LATCH_RST;
			main_latch <= psd_pkg::MAIN_LATCH_RST;
		end else begin
			ref_latch <= next_ref_latch;
			main_latch <= next_main_latch;
		end
	end

	// ==========================================================
	// Reference counter
	logic [REF_W-1:0] ref_cnt;
	logic [REF_W-1:0] next_ref_cnt;
	logic ref_tick;
	logic next_ref_tick;

	always_comb begin
		next_ref_tick = at_terminal(16'(ref_cnt));
		if (next_ref_tick) begin
			next_ref_cnt = ref_latch[REF_W-1:0];
		end else begin
			next_ref_cnt = REF_W'(ref_cnt - 1'b1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ref_cnt <= psd_pkg::REF_CNT_RST;
			ref_tick <= 1'b0;
		end else begin
			ref_cnt <= next_ref_cnt;
			ref_tick <= next_ref_tick;
		end
	end

	// ==========================================================
	// Swallow and programmable counters
	// Counting is on synchronised prescaler edges, so the prescaler
	// output must stay well below half the system clock rate.
	logic [SWAL_W-1:0] swal_cnt;
	logic [PROG_W-1:0] prog_cnt;
	logic fb_tick;
	logic [SWAL_W-1:0] next_swal_cnt;
	logic [PROG_W-1:0] next_prog_cnt;
	logic next_fb_tick;

	always_comb begin
		next_swal_cnt = swal_cnt;
		next_prog_cnt = prog_cnt;
		next_fb_tick = 1'b0;
		if (pulse_edge) begin
			if (at_terminal(16'(prog_cnt))) begin
				next_fb_tick = 1'b1;
				next_prog_cnt = main_latch[psd_pkg::MAIN_LATCH_W-1:psd_pkg::LATCH_PROG_LSB];
				next_swal_cnt = main_latch[SWAL_W-1:0];
			end else begin
				next_prog_cnt = PROG_W'(prog_cnt - 1'b1);
				if (swal_cnt != '0) begin
					next_swal_cnt = SWAL_W'(swal_cnt - 1'b1);
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			swal_cnt <= psd_pkg::SWAL_CNT_RST;
			prog_cnt <= psd_pkg::PROG_CNT_RST;
			fb_tick <= 1'b0;
		end else begin
			swal_cnt <= next_swal_cnt;
			prog_cnt <= next_prog_cnt;
			fb_tick <= next_fb_tick;
		end
	end

	// ==========================================================
	// Phase detector
	psd_pkg::psd_pfd_t pfd_state;
	psd_pkg::psd_pfd_t next_pfd_state;

	always_comb begin
		next_pfd_state = pfd_state;
		case (pfd_state)
			psd_pkg::PFD_IDLE: begin
				if (ref_tick && !fb_tick) begin
					next_pfd_state = psd_pkg::PFD_UP;
				end else if (fb_tick && !ref_tick) begin
					next_pfd_state = psd_pkg::PFD_DOWN;
				end
			end
			psd_pkg::PFD_UP: begin
				if (fb_tick && !ref_tick) begin
					next_pfd_state = psd_pkg::PFD_IDLE;
				end
			end
			psd_pkg::PFD_DOWN: begin
				if (ref_tick && !fb_tick) begin
					next_pfd_state = psd_pkg::PFD_IDLE;
				end
			end
			default: begin
				next_pfd_state = psd_pkg::PFD_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pfd_state <= psd_pkg::PFD_IDLE;
		end else begin
			pfd_state <= next_pfd_state;
		end
	end

	// ==========================================================
	// Output stage
	logic ahead;
	logic behind;
	logic drive_high;
	logic drive_low;
	logic next_ratio_select;
	logic next_modulus_high;
	logic next_lock;
	logic next_pump_out;
	logic next_pump_oe;
	logic next_phase_ref;
	logic next_phase_fb_oe;
	logic next_switch_out;
	logic next_switch_oe;
	logic next_monitor;

	always_comb begin
		ahead = (pfd_state == psd_pkg::PFD_UP);
		behind = (pfd_state == psd_pkg::PFD_DOWN);
		drive_high = sense_level ? ahead : behind;
		drive_low = sense_level ? behind : ahead;
		next_ratio_select = ref_latch[psd_pkg::LATCH_SEL_BIT];
		next_modulus_high = (next_swal_cnt != '0);
		next_lock = ~(ahead | behind);
		next_pump_oe = drive_high | drive_low;
		next_pump_out = drive_high;
		next_phase_ref = drive_low;
		next_phase_fb_oe = drive_high;
		next_switch_oe = strobe_level & next_pump_oe;
		next_switch_out = strobe_level & drive_high;
		next_monitor = sense_level ? ref_tick : fb_tick;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			prescaler_ratio_select <= psd_pkg::REF_LATCH_RST[psd_pkg::LATCH_SEL_BIT];
			modulus_high <= 1'b0;
			lock_indicator <= 1'b1;
			pump_out <= 1'b0;
			pump_oe <= 1'b0;
			phase_ref_out <= 1'b0;
			phase_fb_oe <= 1'b0;
			loop_switch_out <= 1'b0;
			loop_switch_oe <= 1'b0;
			divider_monitor <= 1'b0;
		end else begin
			prescaler_ratio_select <= next_ratio_select;
			modulus_high <= next_modulus_high;
			lock_indicator <= next_lock;
			pump_out <= next_pump_out;
			pump_oe <= next_pump_oe;
			phase_ref_out <= next_phase_ref;
			phase_fb_oe <= next_phase_fb_oe;
			loop_switch_out <= next_switch_out;
			loop_switch_oe <= next_switch_oe;
			divider_monitor <= next_monitor;
		end
	end

	// Open drain: only ever pulls low
	assign phase_fb_out = 1'b0;

endmodule

// ==== tb/psd_core_chk.sv ====
module psd_core_chk #(
	parameter int REF_W = psd_pkg::REF_CNT_W,
	parameter int SWAL_W = psd_pkg::SWAL_W,
	parameter int PROG_W = psd_pkg::PROG_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic load_strobe,
	input wire logic phase_sense_pin,
	input wire logic prescaler_pulse_in,
	input wire logic prescaler_ratio_select,
	input wire logic modulus_high,
	input wire logic lock_indicator,
	input wire logic pump_out,
	input wire logic pump_oe,
	input wire logic phase_ref_out,
	input wire logic phase_fb_out,
	input wire logic phase_fb_oe,
	input wire logic loop_switch_out,
	input wire logic loop_switch_oe,
	input wire logic divider_monitor
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Phase outputs
	chk_fb_drain: assert property (phase_fb_out == 1'b0)
		else $error("fb output driven high");
	chk_ref_inverse: assert property (pump_oe |-> phase_ref_out != pump_out)
		else $error("ref output not opposite to pump");
	chk_fb_pull: assert property (phase_fb_oe == (pump_oe && pump_out))
		else $error("fb pull mismatch");
	chk_idle_ref: assert property (!pump_oe |-> !phase_ref_out)
		else $error("ref output high while idle");
	chk_lock_pump: assert property (lock_indicator != pump_oe)
		else $error("lock indicator disagrees with detector");
	// ==========================================================
	// Loop switch, two sync stages plus one register
	chk_sw_off: assert property (!load_strobe [*4] |-> !loop_switch_oe)
		else $error("loop switch on with strobe low");
	chk_sw_copy: assert property (load_strobe [*4] ##0 ($stable(pump_oe) && $stable(pump_out))
		|-> loop_switch_oe == pump_oe && (!pump_oe || loop_switch_out == pump_out))
		else $error("loop switch not copying pump");
	// Latch only moves while the strobe is high
	chk_sel_hold: assert property (!load_strobe [*6] |=> $stable(prescaler_ratio_select))
		else $error("ratio select moved without strobe");
	// Sense reaches the monitor three cycles late, so compare those samples
	chk_mon_pulse: assert property (divider_monitor &&
		$past(phase_sense_pin, 2) == $past(phase_sense_pin, 3) |=> !divider_monitor)
		else $error("monitor tick longer than one cycle");
endmodule

// ==== tb/psd_host.sv ====
module psd_host (
	input wire logic sys_clk,
	output logic ser_clk,
	output logic ser_data,
	output logic load_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		load_strobe = 1'b0;
	end
	// ==========================================================
	// Word transfer; clock stands still while strobe is high
	task automatic shift(input logic [19:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			ser_data = w[i];
			#32 ser_clk = 1'b1;
			#32 ser_clk = 1'b0;
		end
		ser_data = ~w[0];
		@(posedge sys_clk) load_strobe <= 1'b1;
		repeat (8) @(posedge sys_clk);
		load_strobe <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic load_ref(input logic sw, input logic [13:0] r);
		shift({4'h0, sw, r, 1'b1}, 16);
	endtask
	task automatic load_main(input logic [10:0] n, input logic [7:0] a);
		shift({n, a, 1'b0}, 20);
	endtask
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic sw; logic [13:0] r; logic [10:0] n; logic [7:0] a;} psd_row_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic phase_sense_pin = 1'b1;
	logic prescaler_pulse_in = 1'b0;
	logic pre_en = 1'b0;
	logic [2:0] pre_cnt = 3'h0;
	logic ser_clk, ser_data, load_strobe, prescaler_ratio_select, modulus_high, lock_indicator;
	logic pump_out, pump_oe, phase_ref_out, phase_fb_out, phase_fb_oe;
	logic loop_switch_out, loop_switch_oe, divider_monitor;
	int n_errors = 0;
	int total_checks = 0;
	// Within host limits: R 8..16383, N 16..2047, A below N
	psd_row_t rows [3] = '{'{1'b1, 14'h0008, 11'h010, 8'h00},
		'{1'b0, 14'h0015, 11'h011, 8'h05}, '{1'b1, 14'h3fff, 11'h100, 8'hff}};
	psd_core u_psd_core (.sys_clk, .rst_n, .ser_clk, .ser_data, .load_strobe,
		.phase_sense_pin, .prescaler_pulse_in, .prescaler_ratio_select, .modulus_high,
		.lock_indicator, .pump_out, .pump_oe, .phase_ref_out, .phase_fb_out, .phase_fb_oe,
		.loop_switch_out, .loop_switch_oe, .divider_monitor);
	psd_host u_psd_host (.sys_clk, .ser_clk, .ser_data, .load_strobe);
	initial forever #12.5 sys_clk = ~sys_clk;
	// Prescaler edges every 8 cycles, above the 4-cycle minimum
	always @(posedge sys_clk) begin
		pre_cnt <= pre_cnt + 3'h1;
		prescaler_pulse_in <= pre_en & pre_cnt[2];
	end
	// ==========================================================
	// Helpers
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic measure(output int c, output int h);
		c = 0;
		h = 0;
		for (int i = 0; i < 20000 && divider_monitor !== 1'b1; i++) tick();
		do begin
			tick();
			c++;
			h += int'(modulus_high === 1'b1);
		end while (divider_monitor !== 1'b1 && c < 20000);
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		int c, h;
		repeat (20) tick();
		check("reset outs", 16'h0021, {10'h0, lock_indicator, pump_oe, loop_switch_oe,
			phase_fb_oe, modulus_high, prescaler_ratio_select});
		@(posedge sys_clk) rst_n <= 1'b1;
		repeat (40) tick();
		check("up sense1", 16'h000d, {11'h0, lock_indicator, pump_oe, pump_out,
			phase_ref_out, phase_fb_oe});
		@(posedge sys_clk) phase_sense_pin <= 1'b0;
		repeat (4) tick();
		check("up sense0", 16'h000a, {11'h0, lock_indicator, pump_oe, pump_out,
			phase_ref_out, phase_fb_oe});
		@(posedge sys_clk) pre_en <= 1'b1;
		foreach (rows[k]) begin
			u_psd_host.load_ref(rows[k].sw, rows[k].r);
			u_psd_host.load_main(rows[k].n, rows[k].a);
			check("ratio sel", {15'h0, rows[k].sw}, {15'h0, prescaler_ratio_select});
			@(posedge sys_clk) phase_sense_pin <= 1'b1;
			repeat (3) tick();
			measure(c, h);
			check("ref period", {2'h0, rows[k].r}, c[15:0]);
			@(posedge sys_clk) phase_sense_pin <= 1'b0;
			repeat (3) tick();
			measure(c, h);
			check("fb period", {2'h0, rows[k].n, 3'h0}, c[15:0]);
			check("high span", {5'h0, rows[k].a, 3'h0}, h[15:0]);
		end
		final_report();
	end
	// Worst case rows take about 1 ms
	initial begin
		#2ms;
		n_errors++;
		final_report();
	end
endmodule
bind psd_core psd_core_chk #(.REF_W(REF_W), .SWAL_W(SWAL_W), .PROG_W(PROG_W)) u_psd_core_chk (
	.sys_clk, .rst_n, .ser_clk, .ser_data, .load_strobe, .phase_sense_pin,
	.prescaler_pulse_in, .prescaler_ratio_select, .modulus_high, .lock_indicator,
	.pump_out, .pump_oe, .phase_ref_out, .phase_fb_out, .phase_fb_oe,
	.loop_switch_out, .loop_switch_oe, .divider_monitor);
